// file: lmie_exec.sv
// Executor of four single-cycle accumulator instructions
// How it works
// RULE1: literal OR into acc, zero flag updated
// RULE2: file OR acc, routed by dest, zero updated
// RULE3: move file reg to acc or itself
// RULE4: move updates zero flag from moved value
// RULE5: literal load leaves all flags unchanged
// RULE6: literal load ignores its two don't-cares
// RULE7: dest one writes result back to file
// RULE8: zero set on zero result, one cycle
`timescale 1ns/1ps
`default_nettype none
module lmie_exec (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire lmie_pkg::lmie_instr_t instr_i,
    input wire logic [7:0] file_rdata_i,
    output logic [6:0] file_raddr_o,
    output lmie_pkg::lmie_fwrite_t file_wr_o,
    output logic [7:0] acc_o,
    output logic zero_o,
    output logic done_o
);
    import lmie_pkg::*;

    logic [7:0] acc_ff, nxt_acc;
    logic zero_ff, nxt_zero;
    lmie_fwrite_t fwr_ff, nxt_fwr;
    logic done_ff, nxt_done;
    lmie_op_t op;
    logic [7:0] lit;
    logic [6:0] faddr;
    logic dest;
    logic [7:0] result;

    // Field extraction; file address is combinational for same-cycle read
    // The read address leaves without a register: the file must answer in
    // the same cycle, or one-cycle execution would be lost.
    assign lit = instr_i.word[7:0];
    assign faddr = instr_i.word[6:0];
    assign dest = instr_i.word[DEST_BIT];
    assign file_raddr_o = faddr;

    // Opcode decode
    // Literal OR needs all six opcode bits: neighbouring 11_10xx codes
    // belong to other literal operations and must not alias onto it.
    // Literal load matches 11_00xx only; 11_01xx is a different operation.
    // Anything else, or a word without valid, decodes to no operation.
    always_comb begin
        op = LMIE_OP_NONE;
        if (instr_i.valid) begin
            if (instr_i.word[OP_LIT_HI:OP_LIT_LO] == OPC_OR_LIT) begin
                op = LMIE_OP_OR_LIT;
            // RULE6: don't-care bits ignored
            end else if (instr_i.word[LIT_MOVE_HI:LIT_MOVE_LO] == OPC_LOAD_LIT
                    && instr_i.word[LIT_MOVE_SUB_HI:LIT_MOVE_SUB_LO] == OPC_LOAD_SUB) begin
                op = LMIE_OP_LOAD_LIT;
            end else if (instr_i.word[OP_REG_HI:OP_REG_LO] == OPC_OR_REG) begin
                op = LMIE_OP_OR_REG;
            end else if (instr_i.word[OP_REG_HI:OP_REG_LO] == OPC_MOVE_REG) begin
                op = LMIE_OP_MOVE_REG;
            end
        end
    end

    // Execute: next accumulator, flag and write-back
    // Write-back is a one-cycle request taken by the file at the next edge,
    // so a read of that register in the very next cycle still sees old data.
    always_comb begin
        nxt_acc = acc_ff;
        nxt_zero = zero_ff;
        nxt_fwr = '0;
        nxt_done = 1'b0;
        result = 8'h_00;
        case (op)
            // RULE1: literal OR into acc
            LMIE_OP_OR_LIT: begin
                result = acc_ff | lit;
                nxt_acc = result;
                nxt_zero = (result == 8'h_00);
                nxt_done = 1'b1;
            end
            // RULE2: file OR with routing
            LMIE_OP_OR_REG: begin
                result = acc_ff | file_rdata_i;
                nxt_zero = (result == 8'h_00);
                nxt_done = 1'b1;
                // RULE7: dest one writes file
                if (dest) begin
                    nxt_fwr = '{we: 1'b1, addr: faddr, data: result};
                end else begin
                    nxt_acc = result;
                end
            end
            // RULE3: move file register
            LMIE_OP_MOVE_REG: begin
                result = file_rdata_i;
                // RULE4: zero test of moved value
                nxt_zero = (result == 8'h_00);
                nxt_done = 1'b1;
                if (dest) begin
                    nxt_fwr = '{we: 1'b1, addr: faddr, data: result};
                end else begin
                    nxt_acc = result;
                end
            end
            // RULE5: load literal, flags kept
            LMIE_OP_LOAD_LIT: begin
                nxt_acc = lit;
                nxt_done = 1'b1;
            end
            default: begin
                nxt_acc = acc_ff;
            end
        endcase
    end

    // RULE8: state registered in one cycle
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            acc_ff <= ACC_RST;
            zero_ff <= ZERO_RST;
            fwr_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            zero_ff <= nxt_zero;
            fwr_ff <= nxt_fwr;
            done_ff <= nxt_done;
        end
    end

    // Outputs straight from the registers; the read address is the exception
    assign acc_o = acc_ff;
    assign zero_o = zero_ff;
    assign file_wr_o = fwr_ff;
    assign done_o = done_ff;

    // Assertions
    chk_or_lit_acc: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE1
        op == LMIE_OP_OR_LIT |=> acc_o == ($past(acc_o) | $past(lit)) && zero_o == (acc_o == 8'h_00))
        else $error("literal OR result wrong");
    chk_or_reg_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE2
        op == LMIE_OP_OR_REG |=> zero_o == (($past(acc_o) | $past(file_rdata_i)) == 8'h_00))
        else $error("file OR zero flag wrong");
    chk_move_acc_load: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE3
        op == LMIE_OP_MOVE_REG && !dest |=> acc_o == $past(file_rdata_i) && !file_wr_o.we)
        else $error("move to acc wrong");
    chk_move_zero_test: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE4
        op == LMIE_OP_MOVE_REG |=> zero_o == ($past(file_rdata_i) == 8'h_00))
        else $error("move zero flag wrong");
    chk_load_flag_keep: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE5
        op == LMIE_OP_LOAD_LIT |=> $stable(zero_o) && acc_o == $past(lit))
        else $error("literal load wrong");
    chk_load_dontcare: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE6
        instr_i.valid && instr_i.word[13:12] == 2'h_3 && instr_i.word[11:10] == 2'h_0
        |-> op == LMIE_OP_LOAD_LIT)
        else $error("don't-care bits changed decode");
    chk_dest_file_wr: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE7
        (op == LMIE_OP_OR_REG || op == LMIE_OP_MOVE_REG) && dest
        |=> file_wr_o.we && file_wr_o.addr == $past(faddr) && $stable(acc_o))
        else $error("file write-back wrong");
    chk_single_cycle: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE8
        op != LMIE_OP_NONE |=> done_o ##1 (done_o == $past(op != LMIE_OP_NONE)))
        else $error("instruction not done in one cycle");

    // Refused words leave every registered output quiet
    chk_refused_idle: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE8
        op == LMIE_OP_NONE
        |=> !done_o && !file_wr_o.we && $stable(acc_o) && $stable(zero_o))
        else $error("refused word changed state");

    // Literal OR only on its exact six-bit code
    chk_or_lit_code: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE1
        op == LMIE_OP_OR_LIT |-> instr_i.word[13:8] == 6'h_38)
        else $error("literal OR decoded from wrong code");

    // Literal load only on 11_00xx
    chk_load_code: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE6
        op == LMIE_OP_LOAD_LIT |-> instr_i.word[13:10] == 4'h_C)
        else $error("literal load decoded from wrong code");

    // Literal OR and load never write the file
    chk_lit_no_write: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE5
        op == LMIE_OP_OR_LIT || op == LMIE_OP_LOAD_LIT |=> !file_wr_o.we)
        else $error("literal operation wrote the file");

    // File OR to the accumulator
    chk_or_reg_acc: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE2
        op == LMIE_OP_OR_REG && !dest
        |=> acc_o == ($past(acc_o) | $past(file_rdata_i)) && !file_wr_o.we)
        else $error("file OR to accumulator wrong");

    // Write-back data follows the operation
    chk_wr_data: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE7
        (op == LMIE_OP_OR_REG || op == LMIE_OP_MOVE_REG) && dest
        |=> file_wr_o.data == ($past(file_rdata_i)
            | ($past(op == LMIE_OP_OR_REG) ? $past(acc_o) : 8'h_00)))
        else $error("write-back data wrong");

    // Zero flag set on a zero result of a move to the accumulator, cleared otherwise
    chk_zero_value: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE8
        op == LMIE_OP_MOVE_REG && !dest |=> zero_o == (acc_o == 8'h_00))
        else $error("zero flag disagrees with result");

    // Reset clears the accumulator, the flag and both pulses
    chk_reset_state: assert property (@(posedge clk_sys_i) // RULE8
        srst_i |=> acc_o == ACC_RST && zero_o == ZERO_RST && !done_o && !file_wr_o.we)
        else $error("reset state wrong");

    // Move back to itself leaves the accumulator alone
    chk_move_self_keep: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE3
        op == LMIE_OP_MOVE_REG && dest
        |=> $stable(acc_o) && file_wr_o.data == $past(file_rdata_i))
        else $error("move to itself wrong");

    // Write-back pulse lasts one cycle
    chk_wr_one_cycle: assert property (@(posedge clk_sys_i) disable iff (srst_i) // RULE7
        file_wr_o.we
        |=> !file_wr_o.we
            || $past((op == LMIE_OP_OR_REG || op == LMIE_OP_MOVE_REG) && dest))
        else $error("write-back pulse stretched");
endmodule // lmie_exec
`default_nettype wire

// file: lmie_pkg.sv
// Package for the accumulator instruction executor: encodings, fields, types
package lmie_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    // Opcode field positions
    localparam int OP_LIT_HI = 13;
    localparam int OP_LIT_LO = 8;
    localparam int OP_REG_HI = 13;
    localparam int OP_REG_LO = 8;
    localparam int LIT_MOVE_HI = 13;
    localparam int LIT_MOVE_LO = 12;
    localparam int LIT_MOVE_SUB_HI = 11;
    localparam int LIT_MOVE_SUB_LO = 10;
    localparam int DEST_BIT = 7;
    // Opcode values
    localparam logic [5:0] OPC_OR_LIT = 6'h_38;
    localparam logic [5:0] OPC_OR_REG = 6'h_04;
    localparam logic [5:0] OPC_MOVE_REG = 6'h_08;
    localparam logic [1:0] OPC_LOAD_LIT = 2'h_3;
    localparam logic [1:0] OPC_LOAD_SUB = 2'h_0;
    // Reset values
    localparam logic [7:0] ACC_RST = 8'h_00;
    localparam logic ZERO_RST = 1'b0;

    // Decoded operation
    typedef enum logic [2:0] {
        LMIE_OP_NONE = 3'b000,
        LMIE_OP_OR_LIT = 3'b001,
        LMIE_OP_OR_REG = 3'b010,
        LMIE_OP_MOVE_REG = 3'b011,
        LMIE_OP_LOAD_LIT = 3'b100
    } lmie_op_t;

    // Instruction word with its valid strobe
    typedef struct packed {
        logic valid;
        logic [13:0] word;
    } lmie_instr_t;

    // File register write-back request
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } lmie_fwrite_t;
endpackage // lmie_pkg

// file: lmie_file_mem.sv
// File register model answering the executor's reads and write-backs
`timescale 1ns/1ps
`default_nettype none
module lmie_file_mem (
    input wire logic clk_sys_i,
    input wire logic [6:0] raddr_i,
    input wire lmie_pkg::lmie_fwrite_t wr_i,
    output logic [7:0] rdata_o
);
    import lmie_pkg::*;
    logic [7:0] mem [128];
    // Each location starts holding its own address
    initial begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i);
    end
    // Same-cycle read, as the executor expects
    assign rdata_o = mem[raddr_i];
    // Write-back taken on the pulse only
    always @(posedge clk_sys_i) begin
        if (wr_i.we)
            mem[wr_i.addr] <= wr_i.data;
    end
endmodule // lmie_file_mem
`default_nettype wire

// file: lmie_exec_bench.sv
// Self-checking bench for the accumulator instruction executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("Error %0t: got %h expected %h", $time, a, b); end end
module lmie_exec_bench;
    import lmie_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    lmie_instr_t instr = '0;
    lmie_fwrite_t file_wr;
    logic [7:0] file_rdata, acc;
    logic [6:0] file_raddr;
    logic zero, done;
    int n_fail = 0;
    int total_checks = 0;
    lmie_exec u_lmie_exec (.clk_sys_i(clk_sys), .srst_i(srst), .instr_i(instr),
        .file_rdata_i(file_rdata), .file_raddr_o(file_raddr), .file_wr_o(file_wr),
        .acc_o(acc), .zero_o(zero), .done_o(done));
    lmie_file_mem u_lmie_file_mem (.clk_sys_i(clk_sys), .raddr_i(file_raddr),
        .wr_i(file_wr), .rdata_o(file_rdata));
    // 50 MHz clock
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // Present one word for one edge, then look at the result
    task automatic run(input logic [13:0] w, input logic [7:0] a);
        @(posedge clk_sys);
        instr <= {1'b1, w};
        @(posedge clk_sys);
        instr <= '0;
        #1;
        `CHK(done, 1'b1)
        `CHK(acc, a)
    endtask
    // Present one word that must be refused, then check nothing moved
    task automatic run_refused(input logic v, input logic [13:0] w, input logic [7:0] a,
            input logic z);
        @(posedge clk_sys);
        instr <= {v, w};
        @(posedge clk_sys);
        instr <= '0;
        #1;
        `CHK(done, 1'b0)
        `CHK(acc, a)
        `CHK(zero, z)
        `CHK(file_wr.we, 1'b0)
    endtask
    // Literal OR, including an all-zero result
    task automatic t_or_lit;
        run(14'h_309A, 8'h_9A);
        run(14'h_3835, 8'h_BF);
        `CHK(zero, 1'b0)
        run(14'h_3000, 8'h_00);
        run(14'h_3800, 8'h_00);
        `CHK(zero, 1'b1)
    endtask
    // Literal load with each don't-care pattern, zero flag kept
    task automatic t_load;
        for (int d = 0; d < 4; d++) begin
            run({4'b1100, 2'(d), 8'h_5A}, 8'h_5A);
            `CHK(zero, 1'b1)
        end
    endtask
    // File OR to accumulator, then back to the register
    task automatic t_or_reg;
        run(14'h_3091, 8'h_91);
        run(14'h_0413, 8'h_93);
        `CHK(file_wr.we, 1'b0)
        run(14'h_0493, 8'h_93);
        `CHK(file_wr, 16'h_9393)
    endtask
    // Move to self as a zero test, then move to accumulator
    task automatic t_move;
        run(14'h_0880, 8'h_93);
        `CHK(file_wr, 16'h_8000)
        `CHK(zero, 1'b1)
        run(14'h_0813, 8'h_93);
        `CHK(zero, 1'b0)
        run(14'h_0800, 8'h_00);
        `CHK(zero, 1'b1)
    endtask
    // Neighbouring literal codes and a word without valid are refused
    task automatic t_refused;
        run(14'h_3801, 8'h_01);
        `CHK(zero, 1'b0)
        run(14'h_3377, 8'h_77);
        `CHK(zero, 1'b0)
        run_refused(1'b1, 14'h_3955, 8'h_77, 1'b0);
        run_refused(1'b1, 14'h_3455, 8'h_77, 1'b0);
        run_refused(1'b0, 14'h_3000, 8'h_77, 1'b0);
        run(14'h_0880, 8'h_77);
        `CHK(file_wr, 16'h_8000)
        `CHK(zero, 1'b1)
    endtask
    // Mid-run reset, then an instruction right after release
    task automatic t_reset;
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        `CHK(acc, 8'h_00)
        `CHK(zero, 1'b0)
        `CHK(done, 1'b0)
        `CHK(file_wr, 16'h_0000)
        run(14'h_3812, 8'h_12);
        `CHK(zero, 1'b0)
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence after 12 cycles of reset
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        t_or_lit();
        t_load();
        t_or_reg();
        t_move();
        t_refused();
        t_reset();
        stop_test();
    end
    // Watchdog against a hang
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end
endmodule // lmie_exec_bench
`default_nettype wire
